// [include/timer8_pkg.sv]
// Contract
// - capture enable set: either capture flag requests the timer interrupt
// - compare enable set: either compare flag requests the timer interrupt
// - overflow enable set: overflow flag requests the timer interrupt
// - force compare two copies level two to pin two when enabled; no effect in pwm or one-pulse
// - force compare one copies level one to pin one when enabled; no effect in pwm or one-pulse
// - match two drives level two on pin two; pin one in pwm; neither pin in one-pulse
// - match one drives level one on pin one when enabled
// - per-capture edge select: 0 falling edge, 1 rising edge
// - pin one enable only routes output; compare one keeps working
// - pin two enable only routes output; compare two keeps working
// - one-pulse: capture one edge starts one pulse, length by compare one
// - pwm: repeating wave, pulse by compare one, period by compare two
// - clock select 00 /4, 01 /2, 10 /8, 11 oscillator /8000
// - capture one flag sets on capture or pwm period end; read-sequence clear
// - compare one flag sets on match one, not in one-pulse; read-sequence clear
// - overflow flag sets on FFh to 00h; clears via status then counter
// - alternate counter reads same value, never clears overflow flag
// - capture two flag sets on capture two; read-sequence clear
// - compare two flag sets on match two; read-sequence clear
// - disable freezes prescaler and counter, blocks pins, registers stay open
// - capture copies counter into read-only capture register, no reset value
// - counter resets to FCh; writes to either counter register reload it
// - pwm: match two reloads counter with FCh
// - pwm: new compare values take effect at period end
// - both modes set: pwm only
// - pwm: compare flags never set
package timer8_pkg;
    // word byte addresses on apb, registers in the low 8 bits
    localparam logic [7:0] ADDR_CTRL_B   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_A   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_CAP_ONE  = 8'h0C;
    localparam logic [7:0] ADDR_CMP_ONE  = 8'h10;
    localparam logic [7:0] ADDR_CNT      = 8'h14;
    localparam logic [7:0] ADDR_CNT_ALT  = 8'h18;
    localparam logic [7:0] ADDR_CAP_TWO  = 8'h1C;
    localparam logic [7:0] ADDR_CMP_TWO  = 8'h20;
    // control a fields
    localparam int CA_CAP_IE  = 7;
    localparam int CA_CMP_IE  = 6;
    localparam int CA_OVF_IE  = 5;
    localparam int CA_FORCE2  = 4;
    localparam int CA_FORCE1  = 3;
    localparam int CA_LVL2    = 2;
    localparam int CA_EDGE1   = 1;
    localparam int CA_LVL1    = 0;
    // control b fields
    localparam int CB_PIN1_EN = 7;
    localparam int CB_PIN2_EN = 6;
    localparam int CB_OPM     = 5;
    localparam int CB_PWM     = 4;
    localparam int CB_CLK_HI  = 3;
    localparam int CB_CLK_LO  = 2;
    localparam int CB_EDGE2   = 1;
    // status fields
    localparam int ST_CAP1    = 7;
    localparam int ST_CMP1    = 6;
    localparam int ST_OVF     = 5;
    localparam int ST_CAP2    = 4;
    localparam int ST_CMP2    = 3;
    localparam int ST_DISABLE = 2;
    // reset values and masks
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] CMP_RESET   = 8'h00;
    localparam logic [7:0] CNT_RESET   = 8'hFC;
    localparam logic [7:0] CTRL_B_MASK = 8'hFE;
    // prescaler divisors
    localparam int DIV_SEL0 = 4;
    localparam int DIV_SEL1 = 2;
    localparam int DIV_SEL2 = 8;
    localparam int DIV_OSC  = 8000;
endpackage

// [verilog/timer8_capture_compare.sv]
`timescale 1ns/100ps
module timer8_capture_compare #(
    parameter int OSC_DIV = timer8_pkg::DIV_OSC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_tick,
    input  wire logic        capture_one_pin,
    input  wire logic        capture_two_pin,
    output logic             compare_one_pin,
    output logic             compare_one_pin_oe_n,
    output logic             compare_two_pin,
    output logic             compare_two_pin_oe_n,
    output logic             timer_irq
);
    import timer8_pkg::*;

    typedef enum logic [1:0] {
        PULSE_IDLE  = 2'b01,
        PULSE_ARMED = 2'b10
    } pulse_state_t;

    logic [7:0] ctrl_a_q, ctrl_b_q, cmp_one_q, cmp_two_q;
    logic [7:0] cmp_one_act_q, cmp_two_act_q;
    logic [7:0] cnt_q, cap_one_q, cap_two_q;
    logic       cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q, disable_q;
    logic       status_seen_q;
    logic [2:0] cap1_sync_q, cap2_sync_q, osc_sync_q;
    logic [12:0] osc_cnt_q;
    logic [2:0] pre_cnt_q;
    logic       out_one_q, out_two_q;
    pulse_state_t pulse_q;

    logic access, wr, rd, tick, pwm_mode, opm_mode;
    logic edge1, edge2, match1, match2, cnt_write, period_end;
    logic [7:0] status_word;

    // apb: zero wait states, unmapped reads give zero and no error
    assign access  = psel && penable;
    assign wr      = access && pwrite;
    assign rd      = access && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    assign pwm_mode = ctrl_b_q[CB_PWM];
    assign opm_mode = ctrl_b_q[CB_OPM] && !pwm_mode;

    // active edge on a synchronised capture pin, 0 falling, 1 rising
    function automatic logic edge_hit(input logic [2:0] s, input logic sel);
        edge_hit = sel ? (s[1] && !s[2]) : (!s[1] && s[2]);
    endfunction

    // bit 0 only ever feeds bit 1; edges are judged on bits 1 and 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap1_sync_q <= 3'b000;
            cap2_sync_q <= 3'b000;
            osc_sync_q  <= 3'b000;
        end else begin
            cap1_sync_q <= {cap1_sync_q[1:0], capture_one_pin};
            cap2_sync_q <= {cap2_sync_q[1:0], capture_two_pin};
            osc_sync_q  <= {osc_sync_q[1:0], osc_tick};
        end
    end

    assign edge1 = edge_hit(cap1_sync_q, ctrl_a_q[CA_EDGE1]);
    assign edge2 = edge_hit(cap2_sync_q, ctrl_b_q[CB_EDGE2]);

    // prescaler: pclk divided by 4, 2, 8, or oscillator edges divided
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 3'd0;
            osc_cnt_q <= 13'd0;
        end else if (!disable_q) begin
            pre_cnt_q <= pre_cnt_q + 3'd1;
            if (osc_sync_q[1] && !osc_sync_q[2]) begin
                if (osc_cnt_q == 13'(OSC_DIV - 1))
                    osc_cnt_q <= 13'd0;
                else
                    osc_cnt_q <= osc_cnt_q + 13'd1;
            end
        end
    end

    // tick selection by clock select field
    always_comb begin
        case (ctrl_b_q[CB_CLK_HI:CB_CLK_LO])
            2'b00:   tick = pre_cnt_q[1:0] == 2'(DIV_SEL0 - 1);
            2'b01:   tick = pre_cnt_q[0] == 1'(DIV_SEL1 - 1);
            2'b10:   tick = pre_cnt_q == 3'(DIV_SEL2 - 1);
            default: tick = osc_sync_q[1] && !osc_sync_q[2]
                            && osc_cnt_q == 13'(OSC_DIV - 1);
        endcase
        if (disable_q)
            tick = 1'b0;
    end

    assign match1 = tick && cnt_q == cmp_one_act_q;
    assign match2 = tick && cnt_q == cmp_two_act_q;
    assign period_end = pwm_mode && match2;
    assign cnt_write  = wr && (paddr == ADDR_CNT || paddr == ADDR_CNT_ALT);

    // counter: reload on write, pwm period end, or pulse trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_q <= CNT_RESET;
        else if (cnt_write)
            cnt_q <= CNT_RESET;
        else if (period_end)
            cnt_q <= CNT_RESET;
        else if (opm_mode && edge1 && !disable_q)
            cnt_q <= CNT_RESET;
        else if (tick)
            cnt_q <= cnt_q + 8'd1;
    end

    // control and compare registers, software side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_q  <= CTRL_RESET;
            ctrl_b_q  <= CTRL_RESET;
            cmp_one_q <= CMP_RESET;
            cmp_two_q <= CMP_RESET;
            disable_q <= 1'b0;
        end else if (wr) begin
            case (paddr)
                ADDR_CTRL_A:  ctrl_a_q  <= pwdata[7:0];
                ADDR_CTRL_B:  ctrl_b_q  <= pwdata[7:0] & CTRL_B_MASK;
                ADDR_CMP_ONE: cmp_one_q <= pwdata[7:0];
                ADDR_CMP_TWO: cmp_two_q <= pwdata[7:0];
                ADDR_STATUS:  disable_q <= pwdata[ST_DISABLE];
                default:      ;
            endcase
        end
    end

    // compare values in use: pwm loads them at period end only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_one_act_q <= CMP_RESET;
            cmp_two_act_q <= CMP_RESET;
        end else if (!pwm_mode || period_end) begin
            cmp_one_act_q <= cmp_one_q;
            cmp_two_act_q <= cmp_two_q;
        end
    end

    // capture registers: no reset, they hold whatever was caught last
    always_ff @(posedge pclk) begin
        if (edge1 && !pwm_mode && !opm_mode)
            cap_one_q <= cnt_q;
        if (edge2)
            cap_two_q <= cnt_q;
    end

    // a status read arms the clear; any other access disarms it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            status_seen_q <= 1'b0;
        else if (access)
            status_seen_q <= rd && paddr == ADDR_STATUS;
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap1_f_q <= 1'b0;
            cmp1_f_q <= 1'b0;
            ovf_f_q  <= 1'b0;
            cap2_f_q <= 1'b0;
            cmp2_f_q <= 1'b0;
        end else begin
            if ((edge1 && !pwm_mode && !opm_mode) || period_end)
                cap1_f_q <= 1'b1;
            else if (access && status_seen_q && paddr == ADDR_CAP_ONE)
                cap1_f_q <= 1'b0;
            if (match1 && !pwm_mode && !opm_mode)
                cmp1_f_q <= 1'b1;
            else if (access && status_seen_q && paddr == ADDR_CMP_ONE)
                cmp1_f_q <= 1'b0;
            if (tick && cnt_q == 8'hFF && !period_end)
                ovf_f_q <= 1'b1;
            else if (access && status_seen_q && paddr == ADDR_CNT)
                ovf_f_q <= 1'b0;
            if (edge2)
                cap2_f_q <= 1'b1;
            else if (access && status_seen_q && paddr == ADDR_CAP_TWO)
                cap2_f_q <= 1'b0;
            if (match2 && !pwm_mode)
                cmp2_f_q <= 1'b1;
            else if (access && status_seen_q && paddr == ADDR_CMP_TWO)
                cmp2_f_q <= 1'b0;
        end
    end

    // one-pulse sequencer: trigger edge, then end at compare one match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pulse_q <= PULSE_IDLE;
        else begin
            case (pulse_q)
                PULSE_IDLE:
                    if (opm_mode && edge1 && !disable_q)
                        pulse_q <= PULSE_ARMED;
                PULSE_ARMED:
                    if (!opm_mode || match1)
                        pulse_q <= PULSE_IDLE;
                default: pulse_q <= PULSE_IDLE;
            endcase
        end
    end

    // output levels; level two goes to pin one in pulse and pwm modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_one_q <= 1'b0;
            out_two_q <= 1'b0;
        end else begin
            if (pwm_mode) begin
                if (period_end)
                    out_one_q <= ctrl_a_q[CA_LVL2];
                else if (match1)
                    out_one_q <= ctrl_a_q[CA_LVL1];
            end else if (opm_mode) begin
                if (pulse_q == PULSE_IDLE && edge1 && !disable_q)
                    out_one_q <= ctrl_a_q[CA_LVL2];
                else if (pulse_q == PULSE_ARMED && match1)
                    out_one_q <= ctrl_a_q[CA_LVL1];
            end else if (match1 || ctrl_a_q[CA_FORCE1]) begin
                out_one_q <= ctrl_a_q[CA_LVL1];
            end
            if (!pwm_mode && !opm_mode && (match2 || ctrl_a_q[CA_FORCE2]))
                out_two_q <= ctrl_a_q[CA_LVL2];
        end
    end

    // pins: enable only routes the level; disable releases both pins
    assign compare_one_pin = out_one_q;
    assign compare_two_pin = out_two_q;
    assign compare_one_pin_oe_n = !(ctrl_b_q[CB_PIN1_EN] && !disable_q);
    assign compare_two_pin_oe_n = !(ctrl_b_q[CB_PIN2_EN] && !disable_q);

    // one interrupt line from the three enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            timer_irq <= 1'b0;
        else
            timer_irq <= (ctrl_a_q[CA_CAP_IE] && (cap1_f_q || cap2_f_q))
                      || (ctrl_a_q[CA_CMP_IE] && (cmp1_f_q || cmp2_f_q))
                      || (ctrl_a_q[CA_OVF_IE] && ovf_f_q);
    end

    assign status_word = {cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q,
                          disable_q, 2'b00};

    // read data registered in the setup cycle, ready in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable) begin
            case (paddr)
                ADDR_CTRL_A:  prdata <= {24'h0, ctrl_a_q};
                ADDR_CTRL_B:  prdata <= {24'h0, ctrl_b_q};
                ADDR_STATUS:  prdata <= {24'h0, status_word};
                ADDR_CAP_ONE: prdata <= {24'h0, cap_one_q};
                ADDR_CMP_ONE: prdata <= {24'h0, cmp_one_q};
                ADDR_CNT:     prdata <= {24'h0, cnt_q};
                ADDR_CNT_ALT: prdata <= {24'h0, cnt_q};
                ADDR_CAP_TWO: prdata <= {24'h0, cap_two_q};
                ADDR_CMP_TWO: prdata <= {24'h0, cmp_two_q};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// [testbench/timer8_capture_compare_monitor.sv]
`timescale 1ns/100ps
module timer8_capture_compare_monitor #(
    parameter int OSC_DIV = timer8_pkg::DIV_OSC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        compare_one_pin_oe_n,
    input wire logic        compare_two_pin_oe_n,
    input wire logic        timer_irq
);
    import timer8_pkg::*;
    logic       en1_q, en2_q, dis_q, wr_fire, rd_fire, unmapped;
    logic [2:0] ie_q;
    assign wr_fire  = psel && penable && pwrite;
    assign rd_fire  = psel && penable && !pwrite;
    assign unmapped = paddr > ADDR_CMP_TWO || paddr[1:0] != 2'b00;
    // shadow of routing and enable bits, taken at the write edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en1_q <= 1'b0;
            en2_q <= 1'b0;
            dis_q <= 1'b0;
            ie_q  <= 3'h0;
        end else if (wr_fire) begin
            if (paddr == ADDR_CTRL_B) begin
                en1_q <= pwdata[CB_PIN1_EN];
                en2_q <= pwdata[CB_PIN2_EN];
            end
            if (paddr == ADDR_STATUS)
                dis_q <= pwdata[ST_DISABLE];
            if (paddr == ADDR_CTRL_A)
                ie_q <= pwdata[7:5];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_high_a: assert property (pready)
        else $error("pready low");
    no_slverr_a: assert property (!pslverr)
        else $error("pslverr raised");
    upper_zero_a: assert property (rd_fire |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    unmapped_zero_a: assert property (rd_fire && unmapped |-> prdata == 0)
        else $error("unmapped read not zero");
    ctrlb_resv_a: assert property (rd_fire && paddr == ADDR_CTRL_B
        |-> !prdata[0]) else $error("control b bit 0 set");
    status_resv_a: assert property (rd_fire && paddr == ADDR_STATUS
        |-> prdata[1:0] == 2'b00) else $error("status low bits set");
    // three quiet cycles let any output register catch up
    pin_one_route_a: assert property (
        (!wr_fire)[*3] |-> compare_one_pin_oe_n == !(en1_q && !dis_q))
        else $error("pin one enable wrong");
    pin_two_route_a: assert property (
        (!wr_fire)[*3] |-> compare_two_pin_oe_n == !(en2_q && !dis_q))
        else $error("pin two enable wrong");
    irq_quiet_a: assert property (
        (ie_q == 3'h0)[*3] |-> !timer_irq)
        else $error("irq with all enables clear");
    cover property (timer_irq);
    cover property (rd_fire && unmapped);
    cover property (!compare_one_pin_oe_n && !compare_two_pin_oe_n);
endmodule
bind timer8_capture_compare timer8_capture_compare_monitor #(
    .OSC_DIV(OSC_DIV)
) u_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq),
    .compare_one_pin_oe_n(compare_one_pin_oe_n),
    .compare_two_pin_oe_n(compare_two_pin_oe_n)
);

// [testbench/timer8_pin_model.sv]
`timescale 1ns/100ps
module timer8_pin_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic want_one,
    input  wire logic want_two,
    input  wire logic compare_one_pin,
    input  wire logic compare_one_pin_oe_n,
    input  wire logic compare_two_pin,
    input  wire logic compare_two_pin_oe_n,
    output logic      capture_one_pin,
    output logic      capture_two_pin,
    output logic      seen_one,
    output logic      seen_two
);
    logic last_one_q, last_two_q;
    // capture sources change just after the edge, never mid-cycle
    always_ff @(posedge pclk) begin
        capture_one_pin <= want_one;
        capture_two_pin <= want_two;
    end
    // remember the last driven level of each output line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_one_q <= 1'b0;
            last_two_q <= 1'b0;
        end else begin
            if (!compare_one_pin_oe_n)
                last_one_q <= compare_one_pin;
            if (!compare_two_pin_oe_n)
                last_two_q <= compare_two_pin;
        end
    end
    // a released line has no pull: show the inverse so stale levels fail
    assign seen_one = compare_one_pin_oe_n ? ~last_one_q : compare_one_pin;
    assign seen_two = compare_two_pin_oe_n ? ~last_two_q : compare_two_pin;
endmodule

// [testbench/timer8_capture_compare_bench.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end
module timer8_capture_compare_bench;
    import timer8_pkg::*;
    localparam int OSC_SIM = 4;
    logic        pclk, presetn, psel, penable, pwrite, want_one, want_two;
    logic        pready, pslverr, c1, c2, p1, p1_oe_n, p2, p2_oe_n, irq;
    logic        s1, s2, osc_tick;
    logic [7:0]  paddr, rv, lf, a;
    logic [31:0] pwdata, prdata;
    logic [1:0]  oc = 2'h0;
    int          n_errors = 0;
    int          n_checks = 0;
    int          hi;
    int          dv[4] = '{DIV_SEL0, DIV_SEL1, DIV_SEL2, 3 * OSC_SIM};
    timer8_capture_compare #(.OSC_DIV(OSC_SIM)) u_timer8_capture_compare (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
        .capture_one_pin(c1), .capture_two_pin(c2), .compare_one_pin(p1),
        .compare_one_pin_oe_n(p1_oe_n), .compare_two_pin(p2),
        .compare_two_pin_oe_n(p2_oe_n), .timer_irq(irq));
    timer8_pin_model u_timer8_pin_model (
        .pclk(pclk), .presetn(presetn), .want_one(want_one),
        .want_two(want_two), .compare_one_pin(p1),
        .compare_one_pin_oe_n(p1_oe_n), .compare_two_pin(p2),
        .compare_two_pin_oe_n(p2_oe_n), .capture_one_pin(c1),
        .capture_two_pin(c2), .seen_one(s1), .seen_two(s2));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // oscillator rises every third cycle so its rate differs from /8
    always @(posedge pclk) oc <= (oc == 2'h2) ? 2'h0 : oc + 2'h1;
    assign osc_tick = (oc == 2'h0);
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // prescaler phase is unknown, so allow two ticks either way
    function automatic logic near(input logic [7:0] g, input logic [7:0] e);
        logic [7:0] d;
        d = g - e + 8'h02;
        return d <= 8'h04;
    endfunction
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        apb(1'b1, ad, d);
    endtask
    task automatic rd(input logic [7:0] ad);
        apb(1'b0, ad, 8'h00);
    endtask
    task automatic clr(input logic [7:0] ad);
        rd(ADDR_STATUS);
        rd(ad);
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, want_one} = 5'h00;
        want_two = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        lf = 8'h09;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CNT); `CHK(near(rv, CNT_RESET), 1'b1)
        rd(ADDR_STATUS); `CHK(rv, 8'h00)
        rd(ADDR_CTRL_A); `CHK(rv, CTRL_RESET)
        rd(ADDR_CTRL_B); `CHK(rv, CTRL_RESET)
        rd(ADDR_CMP_ONE); `CHK(rv, CMP_RESET)
        rd(ADDR_CMP_TWO); `CHK(rv, CMP_RESET)
        for (int i = 0; i < 3; i++) begin
            lf = nx(lf);
            wr(ADDR_CMP_ONE, lf);
            wr(ADDR_CMP_TWO, ~lf);
            rd(ADDR_CMP_ONE); `CHK(rv, lf)
            rd(ADDR_CMP_TWO); `CHK(rv, ~lf)
        end
        wr(8'h30, 8'hFF);
        rd(8'h24); `CHK(rv, 8'h00)
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_B, 8'(i << 2));
            wr(ADDR_CNT_ALT, 8'h00);
            repeat (96) @(posedge pclk);
            rd(ADDR_CNT); `CHK(near(rv, CNT_RESET + 8'(96 / dv[i])), 1'b1)
            a = rv;
            rd(ADDR_CNT_ALT); `CHK(near(rv, a), 1'b1)
        end
        // overflow flag set and clear sequence, /8 clock
        wr(ADDR_CTRL_B, 8'h08);
        wr(ADDR_CNT, 8'h00);
        clr(ADDR_CNT);
        rd(ADDR_STATUS); `CHK(rv[ST_OVF], 1'b0)
        wr(ADDR_CTRL_A, 8'(1 << CA_OVF_IE));
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        repeat (40) @(posedge pclk);
        `CHK(irq, 1'b1)
        clr(ADDR_CNT_ALT);
        rd(ADDR_STATUS); `CHK(rv[ST_OVF], 1'b1)
        clr(ADDR_CNT);
        rd(ADDR_STATUS); `CHK(rv[ST_OVF], 1'b0)
        // disable freezes the count and releases both pins
        wr(ADDR_CTRL_B, 8'hC8);
        wr(ADDR_STATUS, 8'(1 << ST_DISABLE));
        rd(ADDR_CNT);
        a = rv;
        repeat (40) @(posedge pclk);
        rd(ADDR_CNT); `CHK(rv, a)
        `CHK({p1_oe_n, p2_oe_n}, 2'b11)
        wr(ADDR_CNT, 8'h00);
        rd(ADDR_CNT); `CHK(rv, CNT_RESET)
        wr(ADDR_STATUS, 8'h00);
        // compare matches with both pins routed
        wr(ADDR_CMP_ONE, 8'h02);
        wr(ADDR_CMP_TWO, 8'h04);
        wr(ADDR_CTRL_A, 8'h05 | 8'(1 << CA_CMP_IE));
        wr(ADDR_CNT, 8'h00);
        repeat (80) @(posedge pclk);
        `CHK({s1, s2}, 2'b11)
        `CHK(irq, 1'b1)
        rd(ADDR_STATUS); `CHK({rv[ST_CMP1], rv[ST_CMP2]}, 2'b11)
        clr(ADDR_CMP_ONE);
        rd(ADDR_STATUS); `CHK(rv[ST_CMP1], 1'b0)
        rd(ADDR_CMP_TWO);
        rd(ADDR_STATUS); `CHK(rv[ST_CMP2], 1'b0)
        wr(ADDR_CTRL_A, 8'(1 << CA_FORCE1) | 8'(1 << CA_FORCE2));
        repeat (3) @(posedge pclk);
        `CHK({s1, s2}, 2'b00)
        // captures: one on rising, two on falling
        wr(ADDR_CTRL_A, 8'(1 << CA_EDGE1) | 8'(1 << CA_CAP_IE));
        clr(ADDR_CAP_ONE);
        clr(ADDR_CAP_TWO);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        rd(ADDR_CNT);
        a = rv;
        want_one <= 1'b1;
        want_two <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK(irq, 1'b1)
        rd(ADDR_STATUS); `CHK({rv[ST_CAP1], rv[ST_CAP2]}, 2'b11)
        rd(ADDR_CAP_ONE); `CHK(near(rv, a), 1'b1)
        rd(ADDR_CAP_TWO); `CHK(near(rv, a), 1'b1)
        clr(ADDR_CAP_ONE);
        want_one <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(ADDR_STATUS); `CHK(rv[ST_CAP1], 1'b0)
        // pwm with one-pulse also set: 5 ticks high of a 13 tick period
        wr(ADDR_CTRL_A, 8'(1 << CA_LVL2));
        rd(ADDR_STATUS);
        wr(ADDR_CMP_ONE, 8'h00);
        rd(ADDR_STATUS);
        wr(ADDR_CMP_TWO, 8'h08);
        wr(ADDR_CTRL_B, 8'hB4);
        // restart from the reload value so the first period is short
        wr(ADDR_CNT, 8'h00);
        repeat (48) @(posedge pclk);
        hi = 0;
        repeat (96) begin
            @(posedge pclk);
            hi += int'(s1);
        end
        `CHK(hi >= 24 && hi <= 40, 1'b1)
        rd(ADDR_CNT); `CHK(rv >= 8'hFC || rv <= 8'h09, 1'b1)
        rd(ADDR_STATUS); `CHK({rv[ST_CMP1], rv[ST_CMP2]}, 2'b00)
        `CHK(rv[ST_CAP1], 1'b1)
        // one-pulse on a rising capture one edge, ends at compare one
        wr(ADDR_CTRL_A, 8'(1 << CA_LVL2) | 8'(1 << CA_EDGE1));
        wr(ADDR_CMP_ONE, 8'h04);
        wr(ADDR_CTRL_B, 8'hA4);
        want_one <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(s1, 1'b1)
        repeat (40) @(posedge pclk);
        `CHK(s1, 1'b0)
        wrap_up();
    end
endmodule
